// ===== include/ifcc_params.svh
// Constants for the float case classifier
`ifndef IFCC_PARAMS_SVH
`define IFCC_PARAMS_SVH

`define IFCC_WORD_WIDTH 32
`define IFCC_SIGN_POS 31
`define IFCC_EXP_MSB 30
`define IFCC_EXP_LSB 23
`define IFCC_EXP_WIDTH 8
`define IFCC_FRAC_MSB 22
`define IFCC_FRAC_WIDTH 23
`define IFCC_LOW_FRAC_MSB 21
`define IFCC_EXP_ALL_ONES 8'hff
`define IFCC_EXP_ALL_ZEROS 8'h00
`define IFCC_EXP_BIAS 8'h7f
`define IFCC_TARGET_ZERO_EXP 8'h80
`define IFCC_NAN_PULSE_HALF_CYCLES 3
`define IFCC_NAN_PULSE_CYCLES ((`IFCC_NAN_PULSE_HALF_CYCLES + 1) / 2)
`define IFCC_WORD_RESET 32'h0000_0000

`endif

// ===== include/ifcc_pkg.sv
// Types for the float case classifier
`include "ifcc_params.svh"

package ifcc_pkg;

	typedef struct packed {
		logic sign;
		logic [`IFCC_EXP_WIDTH-1:0] exponent;
		logic [`IFCC_FRAC_WIDTH-1:0] fraction;
	} ifcc_fields_s;

	typedef struct packed {
		logic not_number;
		logic pos_infinity;
		logic neg_infinity;
		logic pos_normal;
		logic neg_normal_frac;
		logic neg_normal_zero;
		logic pos_denorm_big;
		logic pos_denorm_small;
		logic neg_denorm_big;
		logic neg_denorm_small;
		logic zero;
	} ifcc_case_s;

	typedef struct packed {
		logic exponent_all_ones;
		logic exponent_all_zeros;
		logic low_fraction_zero;
	} ifcc_helper_s;

	typedef logic [`IFCC_EXP_WIDTH-1:0] ifcc_exp_t;

endpackage

// ===== design/ifcc_decode.sv
// Combinational case decode of one IEEE single word
`timescale 1ns/1ns
`include "ifcc_params.svh"

module ifcc_decode
	import ifcc_pkg::*;
(
	// Word under test
	input wire logic [`IFCC_WORD_WIDTH-1:0] word_in,
	// Decoded results
	output ifcc_fields_s fields_out,
	output ifcc_helper_s helper_out,
	output ifcc_case_s case_out
);

	wire logic s;
	wire logic f22;
	wire logic ones;
	wire logic zeros;
	wire logic lowz;
	wire logic mid;

	assign fields_out = '{
		sign: word_in[`IFCC_SIGN_POS],
		exponent: word_in[`IFCC_EXP_MSB:`IFCC_EXP_LSB],
		fraction: word_in[`IFCC_FRAC_MSB:0]
	};

	assign s = fields_out.sign;
	assign f22 = word_in[`IFCC_FRAC_MSB];
	assign ones = &fields_out.exponent;
	assign zeros = ~|fields_out.exponent;
	assign lowz = ~|word_in[`IFCC_LOW_FRAC_MSB:0];
	assign mid = ~zeros & ~ones;

	assign helper_out = '{
		exponent_all_ones: ones,
		exponent_all_zeros: zeros,
		low_fraction_zero: lowz
	};

	assign case_out = '{
		not_number: ones & (f22 | ~lowz),
		pos_infinity: ~s & ones & ~(f22 | ~lowz),
		neg_infinity: s & ones & ~(f22 | ~lowz),
		pos_normal: ~s & mid,
		neg_normal_frac: s & mid & (~lowz | f22),
		neg_normal_zero: s & mid & ~(~lowz | f22),
		pos_denorm_big: ~s & zeros & f22,
		pos_denorm_small: ~s & zeros & ~f22 & ~lowz,
		neg_denorm_big: s & zeros & f22 & ~lowz,
		neg_denorm_small: s & zeros & (f22 ^ ~lowz),
		zero: zeros & ~f22 & lowz
	};

endmodule // ifcc_decode

// ===== design/ifcc_top.sv
// Input classification stage of the IEEE to DSP float converter
// Operation
// - Only 32-bit single precision words handled
// - Bit 31 is sign, one negative
// - Bits 30..23 are biased unsigned exponent
// - Bits 22..0 are the fraction
// - Exponent 255: nonzero fraction NaN, else infinity
// - Mid exponents mean normalized, bias 127
// - Zero exponent, nonzero fraction means denormal
// - Target exponent and mantissa are two's complement
// - Target hidden bit is inverted sign
// - Target zero is exponent minus 128
// - Tiny denormals map to nearest target value
// - Derive all-ones, all-zeros, low-fraction-zero terms
// - Infinity flagged by sign with zero fraction
// - Positive normalized: sign clear, mid exponent
// - Negative normalized with nonzero fraction
// - Negative normalized with zero fraction
// - Positive denormal with fraction bit 22 set
// - Positive denormal, bit 22 clear, low nonzero
// - Negative denormal, bit 22 and low nonzero
// - Negative denormal, exactly one of those
// - Zero: zero exponent and zero fraction
// - NaN conversion pulses active-low interrupt
`timescale 1ns/1ns
`include "ifcc_params.svh"

module ifcc_top
	import ifcc_pkg::*;
#(
	parameter int WORD_WIDTH = `IFCC_WORD_WIDTH
)
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Pins from the buses
	input wire logic [WORD_WIDTH-1:0] memory_side_bus_in,
	input wire logic direction_in,
	input wire logic output_enable_n_in,
	// Classification results
	output logic convert_valid_out,
	output ifcc_case_s case_out,
	output ifcc_helper_s helper_out,
	output ifcc_fields_s fields_out,
	output logic target_zero_out,
	output ifcc_exp_t target_exponent_out,
	// Interrupt
	output logic not_number_irq_n_out
);

	localparam logic [1:0] PULSE_LAST = 2'(`IFCC_NAN_PULSE_CYCLES - 1);

	logic [WORD_WIDTH-1:0] bus_s1;
	logic [WORD_WIDTH-1:0] bus_s2;
	logic dir_s1;
	logic dir_s2;
	logic oe_n_s1;
	logic oe_n_s2;
	logic prev_nan_attempt;
	logic [1:0] pulse_cnt;

	wire ifcc_fields_s dec_fields;
	wire ifcc_helper_s dec_helper;
	wire ifcc_case_s dec_case;
	wire logic attempt;
	wire logic nan_attempt;
	wire logic nan_trigger;
	wire logic maps_to_zero;
	wire logic pulse_active;
	wire ifcc_exp_t next_target_exponent;
	wire logic [1:0] next_pulse_cnt;
	wire logic next_irq_n;

	// Pin synchronisers
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			bus_s1 <= `IFCC_WORD_RESET;
			bus_s2 <= `IFCC_WORD_RESET;
			dir_s1 <= 1'b0;
			dir_s2 <= 1'b0;
			oe_n_s1 <= 1'b1;
			oe_n_s2 <= 1'b1;
		end else begin
			bus_s1 <= memory_side_bus_in;
			bus_s2 <= bus_s1;
			dir_s1 <= direction_in;
			dir_s2 <= dir_s1;
			oe_n_s1 <= output_enable_n_in;
			oe_n_s2 <= oe_n_s1;
		end
	end

	// Case decode of the full 32-bit word
	ifcc_decode u_decode (
		.word_in(bus_s2[`IFCC_WORD_WIDTH-1:0]),
		.fields_out(dec_fields),
		.helper_out(dec_helper),
		.case_out(dec_case)
	);

	assign attempt = dir_s2 & ~oe_n_s2;
	assign nan_attempt = attempt & dec_case.not_number;
	assign nan_trigger = nan_attempt & ~prev_nan_attempt;
	assign maps_to_zero = dec_case.pos_denorm_small | dec_case.neg_denorm_small
		| dec_case.zero;
	assign next_target_exponent = maps_to_zero ? `IFCC_TARGET_ZERO_EXP
		: dec_fields.exponent;
	assign pulse_active = pulse_cnt != 2'h0;
	assign next_pulse_cnt = nan_trigger ? PULSE_LAST
		: (pulse_active ? pulse_cnt - 2'h1 : 2'h0);
	assign next_irq_n = ~(nan_trigger | pulse_active);

	// Registered results
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			convert_valid_out <= 1'b0;
			case_out <= '0;
			helper_out <= '0;
			fields_out <= '0;
			target_zero_out <= 1'b0;
			target_exponent_out <= `IFCC_EXP_ALL_ZEROS;
		end else begin
			convert_valid_out <= attempt;
			case_out <= dec_case;
			helper_out <= dec_helper;
			fields_out <= dec_fields;
			target_zero_out <= maps_to_zero;
			target_exponent_out <= next_target_exponent;
		end
	end

	// Not-a-number interrupt pulse
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			prev_nan_attempt <= 1'b0;
			pulse_cnt <= 2'h0;
			not_number_irq_n_out <= 1'b1;
		end else begin
			prev_nan_attempt <= nan_attempt;
			pulse_cnt <= next_pulse_cnt;
			not_number_irq_n_out <= next_irq_n;
		end
	end

endmodule // ifcc_top

// ===== testbench/ifcc_mem_model.sv
// Memory side model feeding IEEE words
`timescale 1ns/1ns
module ifcc_mem_model (
	input wire logic clk_in,
	input wire logic [31:0] word_in,
	input wire logic read_in,
	output logic [31:0] bus_out,
	output logic dir_out,
	output logic oe_n_out
);
	logic [31:0] last;
	always_ff @(posedge clk_in) if (read_in) last <= word_in;
	assign bus_out = read_in ? word_in : ~last;
	assign dir_out = read_in;
	assign oe_n_out = ~read_in;
endmodule // ifcc_mem_model

// ===== testbench/ifcc_checker.sv
// Port assertions for the classifier
`timescale 1ns/1ns
module ifcc_checker
	import ifcc_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [31:0] memory_side_bus_in,
	input wire logic direction_in,
	input wire logic output_enable_n_in,
	input wire logic convert_valid_out,
	input ifcc_case_s case_out,
	input ifcc_helper_s helper_out,
	input ifcc_fields_s fields_out,
	input wire logic target_zero_out,
	input ifcc_exp_t target_exponent_out,
	input wire logic not_number_irq_n_out
);
	logic [1:0] up;
	always_ff @(posedge clk_in or negedge rst_n_in)
		if (!rst_n_in) up <= 2'h0;
		else if (up != 2'h3) up <= up + 2'h1;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	wire r = up == 2'h3;
	wire [7:0] e = fields_out.exponent;
	wire [22:0] f = fields_out.fraction;
	wire ifcc_case_s c = case_out;
	fld_ok_a: assert property (r |-> fields_out == $past(memory_side_bus_in, 3))
		else $error("fields");
	hlp_ok_a: assert property (r |-> helper_out == {&e, ~|e, ~|f[21:0]})
		else $error("helper");
	one_hot_a: assert property (r |-> $onehot(case_out))
		else $error("onehot");
	nan_case_a: assert property (r |-> c.not_number == (&e && f != 0))
		else $error("nan");
	tz_map_a: assert property (target_zero_out == (c.zero | c.pos_denorm_small | c.neg_denorm_small))
		else $error("tzero");
	texp_a: assert property (target_exponent_out == (target_zero_out ? 8'h80 : e))
		else $error("texp");
	vld_lag_a: assert property (r |-> convert_valid_out == $past(direction_in && !output_enable_n_in, 3))
		else $error("valid");
	irq_go_a: assert property ($rose(c.not_number && convert_valid_out) |-> !not_number_irq_n_out)
		else $error("irq");
	cover property (c.not_number && convert_valid_out);
	cover property (c.neg_denorm_small);
	cover property (r && !convert_valid_out);
endmodule // ifcc_checker
bind ifcc_top ifcc_checker ifcc_checker_i (.*);

// ===== testbench/ifcc_top_test.sv
// Self-checking bench for the classifier
`timescale 1ns/1ns
module ifcc_top_test
	import ifcc_pkg::*;
;
	logic clk = 0, rst_n = 0, rd = 1, a0 = 0, a1 = 0, pn = 0, ps = 0, dir, oe_n, cv, tz, irq_n;
	logic [31:0] w = 0, h0 = 0, h1 = 0, bus;
	ifcc_case_s cs;
	ifcc_helper_s hp;
	ifcc_fields_s fd;
	ifcc_exp_t te;
	int n_mismatch = 0, samples_checked = 0, seed = 40451, cyc = 0;
	logic [32:0] corner [16] = '{33'h17f800001, 33'h17fc00000, 33'h17f800000, 33'h07f800001,
		33'h1ff800000, 33'h13f800000, 33'h1bf800001, 33'h1bf800000, 33'h100400000, 33'h100000001,
		33'h180400001, 33'h180400000, 33'h180000001, 33'h180000000, 33'h1ffc00000, 33'h100000000};
	ifcc_mem_model ifcc_mem_model_i (.clk_in(clk), .word_in(w), .read_in(rd), .bus_out(bus),
		.dir_out(dir), .oe_n_out(oe_n));
	ifcc_top ifcc_top_i (.clk_in(clk), .rst_n_in(rst_n), .memory_side_bus_in(bus),
		.direction_in(dir), .output_enable_n_in(oe_n), .convert_valid_out(cv), .case_out(cs),
		.helper_out(hp), .fields_out(fd), .target_zero_out(tz), .target_exponent_out(te),
		.not_number_irq_n_out(irq_n));
	function automatic ifcc_case_s exp_case(logic [31:0] x);
		logic s, o, z, b, l;
		s = x[31];
		o = &x[30:23];
		z = ~|x[30:23];
		b = x[22];
		l = |x[21:0];
		return '{o & (b | l), ~s & o & ~(b | l), s & o & ~(b | l), ~s & ~z & ~o,
			s & ~z & ~o & (b | l), s & ~z & ~o & ~(b | l), ~s & z & b, ~s & z & ~b & l,
			s & z & b & l, s & z & (b ^ l), z & ~b & ~l};
	endfunction
	task automatic chk(string n, logic [31:0] seen, logic [31:0] want);
		samples_checked++;
		if (seen !== want) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", n, want, seen);
		end
	endtask
	task automatic summarize();
		$display("Checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic step(logic [31:0] nw, logic nr);
		ifcc_case_s c;
		logic st, z;
		@(posedge clk);
		#1;
		c = exp_case(h1);
		z = c.pos_denorm_small | c.neg_denorm_small | c.zero;
		st = a1 & c.not_number & ~pn;
		chk("case", cs, c);
		chk("fields", fd, h1);
		chk("helper", hp, {&h1[30:23], ~|h1[30:23], ~|h1[21:0]});
		chk("tzero", tz, z);
		chk("texp", te, z ? 8'h80 : h1[30:23]);
		chk("valid", cv, a1);
		chk("irq", irq_n, !(st | ps));
		pn = a1 & c.not_number;
		ps = st;
		h1 = h0;
		a1 = a0;
		h0 = bus;
		a0 = dir & ~oe_n;
		w = nw;
		rd = nr;
	endtask
	initial forever #10 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc > 3000) begin
			n_mismatch++;
			summarize();
		end
	end
	initial begin
		logic [31:0] r;
		repeat (12) @(posedge clk);
		chk("reset", {cs, irq_n}, 12'h001);
		#1 rst_n = 1;
		foreach (corner[i]) step(corner[i][31:0], corner[i][32]);
		$display("Test corners done");
		repeat (1000) begin
			r = $random(seed);
			if (r[1]) r[30:23] = {8{r[0]}};
			step(r, r[4:2] != 3'h0);
		end
		$display("Test random done");
		summarize();
	end
endmodule // ifcc_top_test
